// [src/swm_params.svh]
// timing and field constants of the single-wire manchester slave link
`ifndef SWM_PARAMS_SVH
`define SWM_PARAMS_SVH

// ==========================================
// clock and timing
`define SWM_CLK_MHZ 200
`define SWM_STANDBY_PULSE_NS 600000
`define SWM_STANDBY_CYC ((`SWM_STANDBY_PULSE_NS * `SWM_CLK_MHZ + 999) / 1000)
`define SWM_HEADER_LOW_NS 5000
`define SWM_HEADER_LOW_CYC ((`SWM_HEADER_LOW_NS * `SWM_CLK_MHZ + 999) / 1000)

// ==========================================
// counter widths and limits
`define SWM_CW 20
`define SWM_CNT_MAX 20'hFFFFF
`define SWM_TE_MIN_CYC 20'h00008
`define SWM_DRIFT_SHIFT 3

// ==========================================
// bit and frame positions
`define SWM_LAST_DATA_BIT 4'h7
`define SWM_MAK_BIT 4'h8
`define SWM_SAK_BIT 4'h9
`define SWM_SYNC_LAST_EDGE 4'h8
`define SWM_FRAME_MAX 2'h3
`define SWM_ADDR12_PREFIX 4'hF

`endif

// [src/swm_pkg.sv]
// types of the single-wire manchester slave link
package swm_pkg;

   // ==========================================
   // link states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_STANDBY,
      ST_HDR_LOW,
      ST_HDR_SYNC,
      ST_FRAME
   } swm_state_t;

endpackage : swm_pkg

// [src/swm_link.sv]
// slave end of the single-wire manchester link with a two-entry receive buffer
`timescale 1ns/10ps
`default_nettype none
`include "swm_params.svh"

// Overview of operation
// - long high pulse puts slave into standby
// - standby pulse aborts any running command
// - bad ending or byte count is error
// - middle edge direction carries bit value
// - boundary edge only between equal bits
// - tolerate small edge jitter when decoding
// - track bit period drift within command
// - msb-first bytes, bits back to back
// - two-bit acknowledge slot after each byte
// - master_nack ends command, starts processing
// - slave_ack is one, nack leaves undriven
// - no slave_ack until address completes
// - bit period taken from sync byte
// - output tri-stated unless driving own bit
// - standby drops power unless background busy
// - idle ignores traffic until standby pulse
// - standby waits for falling header edge
// - header bit time counted then divided
// - master_ack edge realigns phase and frequency
module swm_link #(
   parameter int unsigned STBY_CYC = `SWM_STANDBY_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic line_in,
   output logic line_out,
   output logic line_oe,
   input wire logic addr12_mode,
   input wire logic [11:0] dev_addr,
   input wire logic tx_dir,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   input wire logic cmd_abort,
   input wire logic bg_busy,
   output logic selected,
   output logic cmd_done,
   output logic link_err,
   output logic low_power,
   output swm_pkg::swm_state_t link_state
);
   import swm_pkg::*;

   // ==========================================
   // declarations
   swm_state_t state_reg;
   logic sync1_reg, line_reg, line_d_reg;
   logic armed_reg;
   logic [`SWM_CW-1:0] hi_cnt_reg, meas_reg, te_reg, ph_reg;
   logic [3:0] edge_cnt_reg, bit_reg;
   logic [1:0] frame_reg;
   logic q1_reg, mak_reg, tx_mode_reg, sak_en_reg;
   logic [7:0] shift_reg, tx_byte_reg;
   logic selected_reg, cmd_done_reg, link_err_reg, tx_ready_reg, low_power_reg;
   logic push_reg;
   logic [7:0] push_data_reg;
   logic head_v_reg, spare_v_reg;
   logic [7:0] head_d_reg, spare_d_reg;
   logic line_out_reg, line_oe_reg;

   logic rise, fall, stby_seen, bit_end, master_bit, full, pop, addr_hi, addr_last;
   logic drive, drive_bit;
   logic [`SWM_CW-1:0] half, quarter, three_q, meas_te;
   logic signed [`SWM_CW:0] phase_err;

   // ==========================================
   // line synchroniser and edge finder
   // reset to high: the idle bus level, so no false edge at release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 1'b1;
         line_reg <= 1'b1;
         line_d_reg <= 1'b1;
      end else begin
         sync1_reg <= line_in;
         line_reg <= sync1_reg;
         line_d_reg <= line_reg;
      end
   end

   assign rise = line_reg & ~line_d_reg;
   assign fall = ~line_reg & line_d_reg;

   // ==========================================
   // standby pulse detector
   // a line held high since reset is not trusted until a rising edge is seen
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         armed_reg <= 1'b0;
      end else if (rise) begin
         armed_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hi_cnt_reg <= '0;
      end else if (!line_reg || !armed_reg) begin
         hi_cnt_reg <= '0;
      end else if (hi_cnt_reg != `SWM_CW'(STBY_CYC)) begin
         hi_cnt_reg <= hi_cnt_reg + 1'b1;
      end
   end

   // an event, not a level: a level would mask the header's falling edge
   assign stby_seen = line_reg && armed_reg && hi_cnt_reg == `SWM_CW'(STBY_CYC - 1);

   // ==========================================
   // bit timing helpers
   // sampling a quarter period each side of the middle absorbs edge jitter
   assign half = te_reg >> 1;
   assign quarter = te_reg >> 2;
   assign three_q = half + quarter;
   assign bit_end = ph_reg == te_reg - 1'b1;
   assign master_bit = (bit_reg <= `SWM_LAST_DATA_BIT && !tx_mode_reg) || bit_reg == `SWM_MAK_BIT;
   assign phase_err = $signed({1'b0, ph_reg}) - $signed({1'b0, half});
   assign meas_te = (meas_reg + 1'b1) >> 3;
   assign full = head_v_reg & spare_v_reg;
   assign pop = head_v_reg & rx_ready;
   assign addr_hi = addr12_mode && frame_reg == 2'h1;
   assign addr_last = addr12_mode ? frame_reg == 2'h2 : frame_reg == 2'h1;

   // ==========================================
   // link state machine
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         meas_reg <= '0;
         edge_cnt_reg <= 4'h0;
         te_reg <= `SWM_TE_MIN_CYC;
         ph_reg <= '0;
         bit_reg <= 4'h0;
         frame_reg <= 2'h0;
         q1_reg <= 1'b0;
         mak_reg <= 1'b0;
         shift_reg <= 8'h00;
         tx_mode_reg <= 1'b0;
         tx_byte_reg <= 8'h00;
         sak_en_reg <= 1'b0;
         selected_reg <= 1'b0;
         cmd_done_reg <= 1'b0;
         link_err_reg <= 1'b0;
         tx_ready_reg <= 1'b0;
         push_reg <= 1'b0;
         push_data_reg <= 8'h00;
      end else begin
         cmd_done_reg <= 1'b0;
         link_err_reg <= 1'b0;
         tx_ready_reg <= 1'b0;
         push_reg <= 1'b0;
         if (stby_seen) begin
            state_reg <= ST_STANDBY;
            selected_reg <= 1'b0;
         end else if (cmd_abort && state_reg == ST_FRAME) begin
            state_reg <= ST_IDLE;
            selected_reg <= 1'b0;
            link_err_reg <= 1'b1;
         end else begin
            unique case (state_reg)
               ST_IDLE: begin
                  state_reg <= ST_IDLE;
               end
               ST_STANDBY: begin
                  if (fall) begin
                     state_reg <= ST_HDR_LOW;
                     meas_reg <= '0;
                  end
               end
               ST_HDR_LOW: begin
                  if (meas_reg != `SWM_CNT_MAX) begin
                     meas_reg <= meas_reg + 1'b1;
                  end
                  if (rise) begin
                     // a glitch shorter than the header low time is not a header
                     if (meas_reg < `SWM_CW'(`SWM_HEADER_LOW_CYC)) begin
                        state_reg <= ST_IDLE;
                        link_err_reg <= 1'b1;
                     end else begin
                        state_reg <= ST_HDR_SYNC;
                        meas_reg <= '0;
                        edge_cnt_reg <= 4'h0;
                     end
                  end
               end
               ST_HDR_SYNC: begin
                  meas_reg <= meas_reg + 1'b1;
                  if (meas_reg == `SWM_CNT_MAX) begin
                     state_reg <= ST_IDLE;
                     link_err_reg <= 1'b1;
                  end else if (rise || fall) begin
                     edge_cnt_reg <= edge_cnt_reg + 1'b1;
                     // eight middle edges, then the falling boundary into master_ack
                     if (edge_cnt_reg == `SWM_SYNC_LAST_EDGE) begin
                        if (!fall || meas_te < `SWM_TE_MIN_CYC) begin
                           state_reg <= ST_IDLE;
                           link_err_reg <= 1'b1;
                        end else begin
                           te_reg <= meas_te;
                           ph_reg <= `SWM_CW'(1);
                           bit_reg <= `SWM_MAK_BIT;
                           frame_reg <= 2'h0;
                           tx_mode_reg <= 1'b0;
                           sak_en_reg <= 1'b0;
                           state_reg <= ST_FRAME;
                        end
                     end
                  end
               end
               ST_FRAME: begin
                  ph_reg <= bit_end ? '0 : ph_reg + 1'b1;
                  if (master_bit && ph_reg == quarter) begin
                     q1_reg <= line_reg;
                  end
                  if (master_bit && ph_reg == three_q) begin
                     if (line_reg == q1_reg) begin
                        state_reg <= ST_IDLE;
                        selected_reg <= 1'b0;
                        link_err_reg <= 1'b1;
                     end else if (bit_reg == `SWM_MAK_BIT) begin
                        mak_reg <= line_reg;
                     end else begin
                        shift_reg <= {shift_reg[6:0], line_reg};
                     end
                  end
                  if (bit_reg == `SWM_MAK_BIT && rise && ph_reg >= quarter && ph_reg <= three_q) begin
                     ph_reg <= half + 1'b1;
                     te_reg <= `SWM_CW'($signed({1'b0, te_reg}) + (phase_err >>> `SWM_DRIFT_SHIFT));
                  end
                  if (bit_end) begin
                     bit_reg <= (bit_reg == `SWM_SAK_BIT) ? 4'h0 : bit_reg + 1'b1;
                     if (bit_reg == `SWM_LAST_DATA_BIT) begin
                        if (tx_mode_reg) begin
                           sak_en_reg <= 1'b1;
                        end else if (selected_reg) begin
                           // a full buffer answers slave_nack so the master retries
                           sak_en_reg <= !full;
                           push_reg <= !full;
                           push_data_reg <= shift_reg;
                        end else if (addr_hi) begin
                           sak_en_reg <= 1'b0;
                           if (shift_reg != {`SWM_ADDR12_PREFIX, dev_addr[11:8]}) begin
                              state_reg <= ST_IDLE;
                           end
                        end else if (addr_last && shift_reg == dev_addr[7:0]) begin
                           selected_reg <= 1'b1;
                           sak_en_reg <= 1'b1;
                        end else begin
                           state_reg <= ST_IDLE;
                        end
                     end
                     if (bit_reg == `SWM_SAK_BIT) begin
                        if (!mak_reg) begin
                           selected_reg <= 1'b0;
                           if (sak_en_reg) begin
                              cmd_done_reg <= 1'b1;
                              state_reg <= ST_STANDBY;
                           end else begin
                              state_reg <= ST_IDLE;
                              link_err_reg <= 1'b1;
                           end
                        end else if (selected_reg && !sak_en_reg) begin
                           state_reg <= ST_IDLE;
                           selected_reg <= 1'b0;
                           link_err_reg <= 1'b1;
                        end else begin
                           frame_reg <= (frame_reg == `SWM_FRAME_MAX) ? frame_reg : frame_reg + 1'b1;
                           sak_en_reg <= 1'b0;
                           tx_mode_reg <= 1'b0;
                           if (selected_reg && tx_dir) begin
                              // no byte ready when the master expects one breaks the count
                              if (tx_valid) begin
                                 tx_byte_reg <= tx_data;
                                 tx_ready_reg <= 1'b1;
                                 tx_mode_reg <= 1'b1;
                              end else begin
                                 state_reg <= ST_IDLE;
                                 selected_reg <= 1'b0;
                                 link_err_reg <= 1'b1;
                              end
                           end
                        end
                     end
                  end
               end
            endcase
         end
      end
   end

   // ==========================================
   // line driver
   // levels per half bit give the boundary edge between equal bits by themselves
   assign drive = state_reg == ST_FRAME &&
                  ((bit_reg <= `SWM_LAST_DATA_BIT && tx_mode_reg) ||
                   (bit_reg == `SWM_SAK_BIT && sak_en_reg));
   assign drive_bit = (bit_reg == `SWM_SAK_BIT) ? 1'b1 : tx_byte_reg[~bit_reg[2:0]];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         line_oe_reg <= 1'b0;
         line_out_reg <= 1'b1;
      end else begin
         line_oe_reg <= drive;
         line_out_reg <= drive ? ((ph_reg < half) ? ~drive_bit : drive_bit) : 1'b1;
      end
   end

   // ==========================================
   // two-entry receive buffer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         head_v_reg <= 1'b0;
         spare_v_reg <= 1'b0;
         head_d_reg <= 8'h00;
         spare_d_reg <= 8'h00;
      end else if (push_reg && pop) begin
         head_d_reg <= spare_v_reg ? spare_d_reg : push_data_reg;
         spare_d_reg <= push_data_reg;
      end else if (pop) begin
         head_d_reg <= spare_d_reg;
         head_v_reg <= spare_v_reg;
         spare_v_reg <= 1'b0;
      end else if (push_reg) begin
         if (!head_v_reg) begin
            head_d_reg <= push_data_reg;
            head_v_reg <= 1'b1;
         end else begin
            spare_d_reg <= push_data_reg;
            spare_v_reg <= 1'b1;
         end
      end
   end

   // ==========================================
   // power state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_power_reg <= 1'b0;
      end else begin
         low_power_reg <= (state_reg == ST_IDLE || state_reg == ST_STANDBY) && !bg_busy;
      end
   end

   // ==========================================
   // outputs
   assign line_out = line_out_reg;
   assign line_oe = line_oe_reg;
   assign tx_ready = tx_ready_reg;
   assign rx_data = head_d_reg;
   assign rx_valid = head_v_reg;
   assign selected = selected_reg;
   assign cmd_done = cmd_done_reg;
   assign link_err = link_err_reg;
   assign low_power = low_power_reg;
   assign link_state = state_reg;

endmodule : swm_link
`default_nettype wire

// [test/swm_link_assertions.sv]
// concurrent checks on the slave link ports
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// port checker
module swm_link_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic line_out,
   input wire logic line_oe,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic bg_busy,
   input wire logic selected,
   input wire logic cmd_done,
   input wire logic link_err,
   input wire logic low_power,
   input wire swm_pkg::swm_state_t link_state
);
   import swm_pkg::*;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // ==========================================
   // line driver
   idle_high_a: assert property (!line_oe |-> line_out)
      else $error("line_out low while released");
   drive_selected_a: assert property (line_oe |-> selected || $past(selected))
      else $error("line driven while not selected");
   drive_frame_a: assert property (line_oe |-> (link_state == ST_FRAME) || ($past(link_state) == ST_FRAME))
      else $error("line driven outside a frame");
   drive_awake_a: assert property (line_oe |-> !low_power)
      else $error("line driven in low power");
   drive_hold_a: assert property ($rose(line_oe) |-> line_oe [*8])
      else $error("drive shorter than a bit");
   // ==========================================
   // command end and errors
   done_standby_a: assert property (cmd_done |-> ##[0:1] link_state == ST_STANDBY)
      else $error("command end not in standby");
   done_pulse_a: assert property (cmd_done |=> !cmd_done)
      else $error("cmd_done longer than a cycle");
   err_idle_a: assert property (link_err |-> ##[0:1] link_state == ST_IDLE)
      else $error("error not followed by idle");
   busy_awake_a: assert property (low_power |-> !$past(bg_busy))
      else $error("low power while busy");
   // ==========================================
   // data path
   rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("stalled word lost");
   tx_take_a: assert property (tx_ready |-> $past(tx_valid) && $past(selected))
      else $error("tx byte taken without request");
   cover property (cmd_done);
   cover property (link_err);
   cover property (tx_ready);
   cover property (rx_valid && !rx_ready ##1 rx_valid && rx_ready);
endmodule : swm_link_assertions
`default_nettype wire

// [test/swm_master_model.sv]
// behavioural bus master on the single wire
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// master model, half a bit lasts HALF = 125 ns, 25 link clock periods
module swm_master_model #(
   parameter real HALF = 125.0,
   parameter real STBY_NS = 1500.0
) (
   input wire logic line,
   output logic m_oe,
   output logic m_out
);
   initial begin
      m_oe = 1'b1;
      m_out = 1'b0;
   end
   task automatic drive(input logic v);
      m_oe = 1'b1;
      m_out = v;
   endtask : drive
   task automatic rel();
      m_oe = 1'b0;
      m_out = 1'b1;
   endtask : rel
   task automatic power_up();
      drive(1'b1);
      #(HALF);
   endtask : power_up
   task automatic standby();
      drive(1'b1);
      #(STBY_NS);
   endtask : standby
   task automatic send_bit(input logic b);
      drive(!b);
      #(HALF);
      drive(b);
      #(HALF);
   endtask : send_bit
   task automatic send_byte(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         send_bit(v[i]);
      end
   endtask : send_byte
   task automatic ack_slot(input logic master_ack, output logic slave_ack);
      logic a;
      send_bit(master_ack);
      rel();
      #(HALF / 2);
      a = line;
      #(HALF);
      slave_ack = !a && line;
      #(HALF / 2);
   endtask : ack_slot
   task automatic recv_byte(output logic [7:0] v);
      rel();
      for (int i = 7; i >= 0; i--) begin
         #(HALF * 1.5);
         v[i] = line;
         #(HALF / 2);
      end
   endtask : recv_byte
   task automatic header(input real low_ns, output logic slave_ack);
      drive(1'b0);
      #(low_ns);
      send_byte(8'h55);
      ack_slot(1'b1, slave_ack);
   endtask : header
endmodule : swm_master_model
`default_nettype wire

// [test/swm_link_tb.sv]
// self-checking bench for the slave link
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// bench top
module swm_link_tb;
   import swm_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic addr12_mode, tx_dir, tx_valid, rx_ready, cmd_abort, bg_busy;
   logic [11:0] dev_addr;
   logic [7:0] tx_data;
   wire logic line;
   logic m_oe, m_out, line_out, line_oe, tx_ready, rx_valid, selected;
   logic cmd_done, link_err, low_power, s;
   logic [7:0] rx_data, d;
   swm_state_t link_state;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_done = 0;
   int n_err = 0;
   int n_txr = 0;
   int c;
   // pull-up: low only when some party drives a zero
   assign line = ((m_oe && !m_out) || (line_oe && !line_out)) ? 1'b0 : 1'b1;
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (cmd_done === 1'b1) n_done <= n_done + 1;
      if (link_err === 1'b1) n_err <= n_err + 1;
      if (tx_ready === 1'b1) n_txr <= n_txr + 1;
   end
   swm_link #(.STBY_CYC(200)) i_swm_link (.clk(clk), .rst(rst), .line_in(line),
      .line_out(line_out), .line_oe(line_oe), .addr12_mode(addr12_mode),
      .dev_addr(dev_addr), .tx_dir(tx_dir), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .cmd_abort(cmd_abort), .bg_busy(bg_busy), .selected(selected), .cmd_done(cmd_done),
      .link_err(link_err), .low_power(low_power), .link_state(link_state));
   swm_master_model i_master (.line(line), .m_oe(m_oe), .m_out(m_out));
   // ==========================================
   // compare and helpers
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8
   task automatic chk1(input string nm, input logic e, input logic g);
      chk8(nm, {7'h00, e}, {7'h00, g});
   endtask : chk1
   task automatic complete_run();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run
   task automatic settle();
      repeat (10) @(posedge clk);
      #1;
   endtask : settle
   task automatic pop(input logic [7:0] e);
      c = 0;
      while (rx_valid !== 1'b1 && c < 100) begin
         @(posedge clk);
         #1;
         c++;
      end
      chk1("rx_valid", 1'b1, rx_valid);
      chk8("rx_data", e, rx_data);
      if (c >= 100) complete_run();
      rx_ready = 1'b1;
      @(posedge clk);
      #1;
      rx_ready = 1'b0;
   endtask : pop
   task automatic select8(input logic stby);
      if (stby) i_master.standby();
      i_master.header(5200.0, s);
      chk1("hdr_sak", 1'b0, s);
      i_master.send_byte(dev_addr[7:0]);
      i_master.ack_slot(1'b1, s);
      chk1("addr_sak", 1'b1, s);
      chk1("selected", 1'b1, selected);
   endtask : select8
   // ==========================================
   // scenarios
   task automatic sc_idle();
      i_master.power_up();
      i_master.header(5200.0, s);
      i_master.send_byte(dev_addr[7:0]);
      i_master.ack_slot(1'b1, s);
      chk1("idle_sak", 1'b0, s);
      settle();
      chk1("idle_state", 1'b1, link_state === ST_IDLE);
   endtask : sc_idle
   task automatic sc_standby();
      i_master.standby();
      settle();
      chk1("stby_state", 1'b1, link_state === ST_STANDBY);
      chk1("low_power", 1'b1, low_power);
      bg_busy = 1'b1;
      settle();
      chk1("busy_power", 1'b0, low_power);
      bg_busy = 1'b0;
   endtask : sc_standby
   task automatic sc_write();
      select8(1'b0);
      i_master.send_byte(8'h5A);
      i_master.ack_slot(1'b0, s);
      chk1("end_sak", 1'b1, s);
      settle();
      chk8("done_cnt", 8'h01, n_done[7:0]);
      chk1("end_state", 1'b1, link_state === ST_STANDBY);
      pop(8'h5A);
   endtask : sc_write
   task automatic sc_read();
      #200;
      settle();
      tx_dir = 1'b1;
      tx_data = 8'hA6;
      tx_valid = 1'b1;
      select8(1'b0);
      fork
         i_master.recv_byte(d);
         begin
            settle();
            tx_valid = 1'b0;
            tx_dir = 1'b0;
         end
      join
      chk8("tx_byte", 8'hA6, d);
      i_master.ack_slot(1'b0, s);
      chk1("rd_sak", 1'b1, s);
      settle();
      chk8("txr_cnt", 8'h01, n_txr[7:0]);
      chk8("done_cnt", 8'h02, n_done[7:0]);
   endtask : sc_read
   task automatic sc_full();
      select8(1'b1);
      i_master.send_byte(8'h3C);
      i_master.ack_slot(1'b1, s);
      chk1("sak1", 1'b1, s);
      i_master.send_byte(8'hC3);
      i_master.ack_slot(1'b1, s);
      chk1("sak2", 1'b1, s);
      i_master.send_byte(8'h99);
      i_master.ack_slot(1'b1, s);
      chk1("full_sak", 1'b0, s);
      settle();
      chk8("err_cnt", 8'h01, n_err[7:0]);
      pop(8'h3C);
      pop(8'hC3);
      settle();
      chk1("drained", 1'b0, rx_valid);
   endtask : sc_full
   task automatic sc_abort();
      select8(1'b1);
      i_master.send_bit(1'b1);
      i_master.send_bit(1'b0);
      i_master.send_bit(1'b1);
      i_master.standby();
      settle();
      chk1("abort_state", 1'b1, link_state === ST_STANDBY);
      chk1("abort_sel", 1'b0, selected);
      select8(1'b0);
      settle();
      cmd_abort = 1'b1;
      @(posedge clk);
      #1;
      cmd_abort = 1'b0;
      settle();
      chk8("err_cnt", 8'h03, n_err[7:0]);
      chk1("abort_idle", 1'b1, link_state === ST_IDLE);
   endtask : sc_abort
   task automatic sc_badhdr();
      i_master.standby();
      i_master.header(2000.0, s);
      settle();
      chk8("err_cnt", 8'h04, n_err[7:0]);
      chk1("bad_idle", 1'b1, link_state === ST_IDLE);
   endtask : sc_badhdr
   task automatic sc_addr12();
      addr12_mode = 1'b1;
      i_master.standby();
      i_master.header(5200.0, s);
      i_master.send_byte({4'hF, dev_addr[11:8]});
      i_master.ack_slot(1'b1, s);
      chk1("hi_sak", 1'b0, s);
      i_master.send_byte(dev_addr[7:0]);
      i_master.ack_slot(1'b0, s);
      chk1("lo_sak", 1'b1, s);
      settle();
      chk8("done_cnt", 8'h03, n_done[7:0]);
      #200;
      i_master.header(5200.0, s);
      i_master.send_byte({4'hF, dev_addr[11:8]});
      i_master.ack_slot(1'b1, s);
      i_master.send_byte(~dev_addr[7:0]);
      i_master.ack_slot(1'b1, s);
      chk1("miss_sak", 1'b0, s);
      settle();
      chk1("miss_idle", 1'b1, link_state === ST_IDLE);
      chk8("miss_err", 8'h04, n_err[7:0]);
      addr12_mode = 1'b0;
   endtask : sc_addr12
   initial begin
      addr12_mode = 1'b0;
      dev_addr = 12'h3A5;
      tx_dir = 1'b0;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      rx_ready = 1'b0;
      cmd_abort = 1'b0;
      bg_busy = 1'b0;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      sc_idle();
      sc_standby();
      sc_write();
      sc_read();
      sc_full();
      sc_abort();
      sc_badhdr();
      sc_addr12();
      complete_run();
   end
   initial begin
      #300000;
      n_mismatch++;
      complete_run();
   end
endmodule : swm_link_tb
bind swm_link swm_link_assertions i_chk (.clk(clk), .rst(rst), .line_out(line_out),
   .line_oe(line_oe), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .bg_busy(bg_busy), .selected(selected),
   .cmd_done(cmd_done), .link_err(link_err), .low_power(low_power),
   .link_state(link_state));
`default_nettype wire
